// *** include/ssv_map.vh ***
`ifndef SSV_MAP_VH
`define SSV_MAP_VH
`define SSV_HIZ_CYCLES 11'h020
`define SSV_CLAMP_END 11'h0B6
`define SSV_SS_LAST 11'h7FF
`define SSV_CODE_OFF 5'h1F
`define SSV_REF_OFF 5'h1F
`define SSV_DUTY_MAX 8'hFF
`endif

// *** verilog/ssv_vid_stepper.v ***
`default_nettype none
`include "ssv_map.vh"
module ssv_vid_stepper (
  input wire i_clk,
  input wire i_rst_b,
  input wire i_run,
  input wire i_cyc_start,
  input wire [4:0] i_code,
  output reg [4:0] o_target,
  output reg o_busy
);
  reg [4:0] cand_r;
  reg pend_r;
  // ---------------------------------------------------------------
  // Code sampling and stability check
  // ---------------------------------------------------------------
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cand_r <= 5'h00;
      pend_r <= 1'b0;
      o_target <= 5'h00;
      o_busy <= 1'b0;
    end else if (!i_run) begin
      pend_r <= 1'b0;
      o_busy <= 1'b0;
      o_target <= i_code;
      cand_r <= i_code;
    end else if (i_cyc_start) begin
      cand_r <= i_code;
      if (pend_r && i_code == cand_r) begin
        o_target <= cand_r;
        pend_r <= 1'b0;
      end else begin
        pend_r <= (i_code != o_target);
      end
      o_busy <= pend_r;
    end
  end
endmodule // ssv_vid_stepper
`default_nettype wire

// *** verilog/ssv_softstart.v ***
`default_nettype none
`include "ssv_map.vh"
module ssv_softstart (
  input wire i_clk,
  input wire i_rst_b,
  input wire i_por_done,
  input wire i_freq_select_enable,
  input wire i_phase_clk,
  input wire [4:0] i_voltage_id_code,
  output reg o_pwm_oe,
  output reg o_pwm_low,
  output reg o_ref_en,
  output reg [4:0] o_ref_code,
  output reg [7:0] o_duty_limit,
  output reg o_power_good_flag
);
  localparam ST_OFF = 4'b0001;
  localparam ST_HIZ = 4'b0010;
  localparam ST_CLAMP = 4'b0100;
  localparam ST_RAMP = 4'b1000;
  reg [3:0] st_r;
  reg [3:0] st_nxt;
  reg [10:0] cnt_r;
  reg ss_done_r;
  reg [1:0] por_s_r;
  reg [1:0] en_s_r;
  reg [2:0] ph_s_r;
  reg [4:0] vid_a_r;
  reg [4:0] vid_b_r;
  reg step_tgl_r;
  wire ph_pulse;
  wire run_ok;
  wire [4:0] target;
  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      por_s_r <= 2'h0;
      en_s_r <= 2'h0;
      ph_s_r <= 3'h0;
      vid_a_r <= 5'h1F;
      vid_b_r <= 5'h1F;
    end else begin
      por_s_r <= {por_s_r[0], i_por_done};
      en_s_r <= {en_s_r[0], i_freq_select_enable};
      ph_s_r <= {ph_s_r[1:0], i_phase_clk};
      vid_a_r <= i_voltage_id_code;
      vid_b_r <= vid_a_r;
    end
  end
  assign ph_pulse = ph_s_r[1] & ~ph_s_r[2];
  assign run_ok = por_s_r[1] & en_s_r[1] & (vid_b_r != `SSV_CODE_OFF);
  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always @* begin
    st_nxt = st_r;
    case (st_r)
      ST_OFF: st_nxt = ST_HIZ;
      ST_HIZ: if (ph_pulse && cnt_r == `SSV_HIZ_CYCLES - 11'h001) st_nxt = ST_CLAMP;
      ST_CLAMP: if (ph_pulse && cnt_r == `SSV_CLAMP_END - 11'h001) st_nxt = ST_RAMP;
      ST_RAMP: st_nxt = ST_RAMP;
      default: st_nxt = ST_OFF;
    endcase
    if (!run_ok) st_nxt = ST_OFF;
  end
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r <= ST_OFF;
      cnt_r <= 11'h000;
      ss_done_r <= 1'b0;
      o_pwm_oe <= 1'b0;
      o_pwm_low <= 1'b0;
      o_ref_en <= 1'b0;
      o_duty_limit <= 8'h00;
      o_power_good_flag <= 1'b0;
    end else begin
      st_r <= st_nxt;
      if (st_nxt == ST_OFF) begin
        cnt_r <= 11'h000;
        ss_done_r <= 1'b0;
      end else if (ph_pulse && !ss_done_r && st_r != ST_OFF) begin
        cnt_r <= cnt_r + 11'h001;
        if (cnt_r == `SSV_SS_LAST) ss_done_r <= 1'b1;
      end
      o_pwm_oe <= (st_nxt == ST_CLAMP) | (st_nxt == ST_RAMP);
      o_pwm_low <= (st_nxt == ST_CLAMP);
      o_ref_en <= (st_nxt == ST_RAMP);
      if (st_nxt != ST_RAMP) o_duty_limit <= 8'h00;
      else if (ph_pulse && o_duty_limit != `SSV_DUTY_MAX) o_duty_limit <= o_duty_limit + 8'h01;
      o_power_good_flag <= (st_nxt == ST_RAMP) & ss_done_r;
    end
  end
  // ---------------------------------------------------------------
  // Reference stepping
  // ---------------------------------------------------------------
  ssv_vid_stepper u_step (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_run(ss_done_r),
    .i_cyc_start(ph_pulse),
    .i_code(vid_b_r),
    .o_target(target),
    .o_busy()
  );
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_ref_code <= `SSV_REF_OFF;
      step_tgl_r <= 1'b0;
    end else if (st_nxt != ST_RAMP) begin
      o_ref_code <= `SSV_REF_OFF;
      step_tgl_r <= 1'b0;
    end else if (ph_pulse) begin
      step_tgl_r <= ~step_tgl_r;
      if (step_tgl_r && o_ref_code > target) o_ref_code <= o_ref_code - 5'h01;
      else if (step_tgl_r && o_ref_code < target) o_ref_code <= o_ref_code + 5'h01;
    end
  end
endmodule // ssv_softstart
`default_nettype wire

// *** tb/ssv_softstart_chk.sv ***
`default_nettype none
module ssv_chk (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic o_pwm_oe,
  input wire logic o_pwm_low,
  input wire logic o_ref_en,
  input wire logic o_power_good_flag,
  input wire logic [4:0] i_voltage_id_code,
  input wire logic [4:0] o_ref_code,
  input wire logic [7:0] o_duty_limit
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_off; i_voltage_id_code == 5'h1F [*4]; endsequence
  a_hiz_quiet: assert property (
    !o_pwm_oe |-> !(o_pwm_low | o_ref_en | o_power_good_flag)) else $error("hiz");
  a_ref_held: assert property (
    !o_ref_en |-> o_ref_code == 5'h1F) else $error("ref off");
  a_clamp_hold: assert property (
    o_pwm_low |-> !o_ref_en && o_duty_limit == 8'h00) else $error("clamp");
  a_duty_ramp: assert property (
    o_pwm_oe && $past(o_pwm_oe) && $changed(o_duty_limit) |-> o_duty_limit == $past(o_duty_limit) + 8'h01)
    else $error("duty");
  a_pg_full: assert property (
    o_power_good_flag |-> o_duty_limit == 8'hFF && !o_pwm_low) else $error("pg");
  a_ref_unit: assert property (
    o_ref_en && $past(o_ref_en) && $changed(o_ref_code) |-> {o_ref_code - $past(o_ref_code)} inside {5'h01, 5'h1F})
    else $error("ref step");
  a_ref_pace: assert property (
    o_ref_en && $changed(o_ref_code) |=> ($stable(o_ref_code) || !o_ref_en) [*8]) else $error("ref pace");
  a_off_stop: assert property (
    s_off |-> ##[0:2] !o_pwm_oe && o_ref_code == 5'h1F) else $error("off");
endmodule // ssv_chk
bind ssv_softstart ssv_chk u_chk (.i_clk, .i_rst_b, .o_pwm_oe, .o_pwm_low, .o_ref_en, .o_power_good_flag,
  .i_voltage_id_code, .o_ref_code, .o_duty_limit);
`default_nettype wire

// *** tb/ssv_phase_src.sv ***
`default_nettype none
module ssv_phase_src (
  input wire logic i_clk,
  output logic o_phase = 1'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] n_r = 3'h0;
  // Phase clock, eight clocks a cycle
  always @(posedge i_clk) begin
    n_r <= n_r + 3'h1;
    o_phase <= !n_r[2];
  end
endmodule // ssv_phase_src
`default_nettype wire

// *** tb/ssv_softstart_tb.sv ***
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin errors++; $display("[ERR] %0t %0h %0h", $time, a, e); end end
module ssv_softstart_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'h0, i_rst_b = 1'h0, i_por_done = 1'h0, i_freq_select_enable = 1'h0, ph, ph_q = 1'h0;
  logic o_pwm_oe, o_pwm_low, o_ref_en, o_power_good_flag;
  logic [4:0] i_voltage_id_code = 5'h1F, o_ref_code;
  logic [7:0] o_duty_limit;
  int errors = 0, num_checks = 0, n = 0, b;
  initial forever #20 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    ph_q <= ph;
    n <= n + (ph && !ph_q);
  end
  ssv_phase_src u_ph (.i_clk, .o_phase(ph));
  ssv_softstart uut (.i_clk, .i_rst_b, .i_por_done, .i_freq_select_enable, .i_phase_clk(ph), .i_voltage_id_code,
    .o_pwm_oe, .o_pwm_low, .o_ref_en, .o_ref_code, .o_duty_limit, .o_power_good_flag);
  task automatic pls(input int k);
    repeat (k) @(posedge ph);
    repeat (5) @(posedge i_clk);
  endtask
  task automatic t_start(input logic [4:0] c);
    pls(1);
    i_voltage_id_code <= c;
    i_por_done <= 1'h1;
    i_freq_select_enable <= 1'h1;
    b = n;
    wait (o_pwm_oe);
    `CHK(n - b, 32)
    wait (!o_pwm_low);
    `CHK(n - b, 182)
    wait (o_power_good_flag);
    `CHK(n - b, 2048)
    `CHK({o_duty_limit, o_ref_code}, {8'hFF, c})
  endtask
  task automatic t_vid;
    pls(1);
    i_voltage_id_code <= 5'h06;
    @(posedge i_clk);
    i_voltage_id_code <= 5'h0A;
    pls(3);
    `CHK(o_ref_code, 5'h0A)
    i_voltage_id_code <= 5'h07;
    pls(1);
    i_voltage_id_code <= 5'h0A;
    pls(4);
    `CHK(o_ref_code, 5'h0A)
    i_voltage_id_code <= 5'h06;
    pls(1);
    `CHK(o_ref_code, 5'h0A)
    pls(11);
    `CHK(o_ref_code, 5'h06)
  endtask
  task automatic t_off;
    i_voltage_id_code <= 5'h1F;
    repeat (6) @(posedge i_clk);
    `CHK({o_pwm_oe, o_power_good_flag, o_ref_code}, 7'h1F)
    t_start(5'h03);
    i_freq_select_enable <= 1'h0;
    repeat (6) @(posedge i_clk);
    `CHK(o_pwm_oe, 1'h0)
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge i_clk);
    i_rst_b <= 1'h1;
    t_start(5'h0A);
    t_vid;
    t_off;
    give_verdict;
  end
  initial begin
    repeat (50000) @(posedge i_clk);
    errors++;
    give_verdict;
  end
endmodule // ssv_softstart_tb
`default_nettype wire
